// *** rtl/gmx_pkg.sv ***
// constants and types shared by the gpio mode block
package gmx_pkg;
   localparam int NPIN     = 8;
   localparam int NCH      = 4;
   localparam int NALM     = 2 * NCH;
   localparam int AW       = 8;
   localparam int DW       = 32;
   localparam int LIVE_W   = 3 * NCH;
   localparam int SYNC_LEN = 3;

   typedef enum logic [2:0] {
      MODE_INPUT,
      MODE_OUTPUT,
      MODE_SIGMISS,
      MODE_LOCK_LIVE,
      MODE_LOCK_STICKY,
      MODE_HOLD_LIVE,
      MODE_HOLD_STICKY,
      MODE_ALERT
   } gmx_mode_e;

   // per-pin configuration word layout
   localparam int MODE_LSB = 0;
   localparam int MODE_W   = 3;
   localparam int INV_BIT  = 3;
   localparam int SRC_LSB  = 4;
   localparam int SRC_W    = 2;
   localparam int OD_BIT   = 6;
   localparam int CFG_W    = 7;

   // alarm vector layout: loss of lock first, holdover after
   localparam int LOCK_BASE = 0;
   localparam int HOLD_BASE = NCH;

   localparam logic [AW-1:0] ADDR_IN_VAL    = 8'h00;
   localparam logic [AW-1:0] ADDR_OUT_VAL   = 8'h04;
   localparam logic [AW-1:0] ADDR_CFG_BASE  = 8'h08;
   localparam int            CFG_STRIDE     = 4;
   localparam logic [AW-1:0] ADDR_LIVE      = 8'h28;
   localparam logic [AW-1:0] ADDR_STICKY    = 8'h2C;
   localparam logic [AW-1:0] ADDR_STICKY_CLR = 8'h30;
   localparam logic [AW-1:0] ADDR_ALERT_EN  = 8'h34;
   localparam logic [AW-1:0] ADDR_IRQ_STAT  = 8'h38;
   localparam logic [AW-1:0] ADDR_IRQ_MASK  = 8'h3C;

   localparam logic [CFG_W-1:0] CFG_RST      = 7'h00;
   localparam logic [NPIN-1:0]  OUT_VAL_RST  = 8'h00;
   localparam logic [NALM-1:0]  ALERT_EN_RST = 8'h00;
   localparam logic [NALM-1:0]  IRQ_MASK_RST = 8'h00;
endpackage

// *** rtl/gmx_alarm_if.sv ***
// live alarms, sticky flags and clears between core and sticky bank
`timescale 1ns/1ps
`default_nettype none
interface gmx_alarm_if;
   logic [gmx_pkg::NALM-1:0] live;
   logic [gmx_pkg::NALM-1:0] clr;
   logic [gmx_pkg::NALM-1:0] sticky;
   logic [gmx_pkg::NALM-1:0] evt;
   modport bank (input live, input clr, output sticky, output evt);
   modport core (output live, output clr, input sticky, input evt);
endinterface
`default_nettype wire

// *** rtl/gmx_pin_sync.sv ***
// three-stage pin synchroniser, value taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gmx_pin_sync (
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   input  wire logic [gmx_pkg::NPIN-1:0]  pin_in,
   output logic      [gmx_pkg::NPIN-1:0]  val_out
);
   logic [gmx_pkg::SYNC_LEN-1:0] stage_r [gmx_pkg::NPIN];
   logic [gmx_pkg::NPIN-1:0]     val_r;

   genvar g;
   generate
      for (g = 0; g < gmx_pkg::NPIN; g++) begin : g_bit
         wire agree_w = stage_r[g][1] == stage_r[g][2];
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               stage_r[g] <= '0;
               val_r[g]   <= 1'b0;
            end else begin
               stage_r[g] <= {stage_r[g][1:0], pin_in[g]};
               if (agree_w) begin
                  val_r[g] <= stage_r[g][2];
               end
            end
         end
      end
   endgenerate

   assign val_out = val_r;
endmodule
`default_nettype wire

// *** rtl/gmx_sticky_bank.sv ***
// sticky change flags for every live alarm, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module gmx_sticky_bank (
   input  wire logic    clk_in,
   input  wire logic    rst_n_in,
   gmx_alarm_if.bank    alm
);
   logic [gmx_pkg::NALM-1:0] prev_r;
   logic [gmx_pkg::NALM-1:0] sticky_r;
   logic [gmx_pkg::NALM-1:0] evt_r;
   logic                     arm_r;

   // first cycle after reset only loads the history
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         arm_r <= 1'b0;
      end else begin
         arm_r <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < gmx_pkg::NALM; g++) begin : g_alm
         wire chg_w = arm_r && (alm.live[g] != prev_r[g]);
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               prev_r[g]   <= 1'b0;
               sticky_r[g] <= 1'b0;
               evt_r[g]    <= 1'b0;
            end else begin
               prev_r[g]   <= alm.live[g];
               evt_r[g]    <= chg_w;
               sticky_r[g] <= chg_w | (sticky_r[g] & ~alm.clr[g]);
            end
         end
      end
   endgenerate

   assign alm.sticky = sticky_r;
   assign alm.evt    = evt_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_sticky_on_change: assert property (arm_r && alm.live[0] != prev_r[0] |=> alm.sticky[0] && alm.evt[0])
      else $error("sticky flag missed a live change");
   a_sticky_holds: assert property (alm.sticky[0] && !alm.clr[0] |=> alm.sticky[0])
      else $error("sticky flag dropped without a clear");
   a_sticky_clears: assert property (alm.sticky[0] && alm.clr[0] && alm.live[0] == prev_r[0] |=> !alm.sticky[0])
      else $error("sticky flag survived its clear");
endmodule
`default_nettype wire

// *** rtl/gmx_gpio_top.sv ***
// multi-mode gpio pins with alarm outputs, sticky flags and register port
// Function
// - each pin configured on its own into one mode, any source per pin.
// - configured modes act only after the device reset sequence completes.
// - input mode samples pin into readable register; input mode is default.
// - output mode drives pin to level from a writable register.
// - pins with identical alarm configuration drive identical values.
// - signal-missing mode drives high on monitor alarm, invertible by register.
// - signal-missing output follows live monitor alarm; monitor chosen by register.
// - lock and holdover modes take their loop channel from register.
// - live lock mode drives high while chosen loop is not locked.
// - sticky lock mode sets high on lock entry or exit and holds.
// - live holdover mode drives high while chosen digital loop is in holdover.
// - sticky holdover mode sets high on holdover entry or exit and holds.
// - sticky lock and holdover modes offer polarity inversion by register.
// - sticky alarm holds until software writes the sticky clear register.
// - alert mode drives OR of enabled sticky bits, active high, invertible.
// - alert drops only after every contributing sticky bit is cleared.
// - sticky bit sets on every live alarm change, both directions; sticky bits exist for lock and holdover alarms only, none for signal missing.
// - lock counts only when digital loop and analog loop are both locked.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module gmx_gpio_top (
   input  wire logic                        REF_CLK_IN,
   input  wire logic                        RST_B_IN,
   input  wire logic                        RESET_DONE_IN,
   input  wire logic [gmx_pkg::NPIN-1:0]    GPIO_IN,
   input  wire logic [gmx_pkg::NCH-1:0]     SIGNAL_MISSING_ALARM_IN,
   input  wire logic [gmx_pkg::NCH-1:0]     DIGITAL_LOCK_LOOP_LOCKED_IN,
   input  wire logic [gmx_pkg::NCH-1:0]     DIGITAL_LOCK_LOOP_HOLDOVER_IN,
   input  wire logic                        ANALOG_LOCK_LOOP_LOCKED_IN,
   input  wire logic [gmx_pkg::AW-1:0]      ADDR_IN,
   input  wire logic [gmx_pkg::DW-1:0]      WR_DATA_IN,
   input  wire logic                        WR_EN_IN,
   input  wire logic                        RD_EN_IN,
   output logic      [gmx_pkg::DW-1:0]      RD_DATA_OUT,
   output logic      [gmx_pkg::NPIN-1:0]    GPIO_OUT,
   output logic      [gmx_pkg::NPIN-1:0]    GPIO_OE_OUT,
   output logic                             IRQ_OUT
);
   logic [1:0]                      rst_sync_r;
   wire                             rst_n;
   logic [gmx_pkg::NPIN-1:0]        in_val;
   logic [gmx_pkg::NPIN-1:0]        out_val_r;
   logic [gmx_pkg::CFG_W-1:0]       cfg_r     [gmx_pkg::NPIN];
   logic [gmx_pkg::CFG_W-1:0]       cfg_rdv   [gmx_pkg::NPIN];
   logic [gmx_pkg::CFG_W-1:0]       cfg_rd;
   logic [gmx_pkg::NPIN-1:0]        cfg_hit;
   gmx_pkg::gmx_mode_e              mode_w    [gmx_pkg::NPIN];
   logic [gmx_pkg::NPIN-1:0]        inv_w;
   logic [gmx_pkg::NPIN-1:0]        od_w;
   logic [gmx_pkg::SRC_W-1:0]       src_w     [gmx_pkg::NPIN];
   logic [gmx_pkg::NPIN-1:0]        pin_nxt;
   logic [gmx_pkg::NPIN-1:0]        oe_nxt;
   logic [gmx_pkg::NPIN-1:0]        gpio_out_r;
   logic [gmx_pkg::NPIN-1:0]        gpio_oe_r;
   logic [gmx_pkg::NCH-1:0]         lock_loss_w;
   logic [gmx_pkg::NALM-1:0]        alert_en_r;
   logic [gmx_pkg::NALM-1:0]        irq_stat_r;
   logic [gmx_pkg::NALM-1:0]        irq_mask_r;
   logic                            irq_r;
   logic [gmx_pkg::DW-1:0]          rd_mux;
   logic [gmx_pkg::DW-1:0]          rd_data_r;
   logic [gmx_pkg::LIVE_W-1:0]      live_rd;
   wire                             alert_w;

   gmx_alarm_if alm ();

   // reset release through two flops
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   gmx_pin_sync u_sync (
      .clk_in   (REF_CLK_IN),
      .rst_n_in (rst_n),
      .pin_in   (GPIO_IN),
      .val_out  (in_val)
   );

   gmx_sticky_bank u_bank (
      .clk_in   (REF_CLK_IN),
      .rst_n_in (rst_n),
      .alm      (alm.bank)
   );

   // live alarm vector
   assign lock_loss_w = ~(DIGITAL_LOCK_LOOP_LOCKED_IN & {gmx_pkg::NCH{ANALOG_LOCK_LOOP_LOCKED_IN}});
   assign alm.live    = {DIGITAL_LOCK_LOOP_HOLDOVER_IN, lock_loss_w};
   assign live_rd     = {DIGITAL_LOCK_LOOP_HOLDOVER_IN, lock_loss_w, SIGNAL_MISSING_ALARM_IN};
   assign alert_w     = |(alm.sticky & alert_en_r);

   // register port decode
   wire wr_out_val  = WR_EN_IN && ADDR_IN == gmx_pkg::ADDR_OUT_VAL;
   wire wr_clr      = WR_EN_IN && ADDR_IN == gmx_pkg::ADDR_STICKY_CLR;
   wire wr_alert_en = WR_EN_IN && ADDR_IN == gmx_pkg::ADDR_ALERT_EN;
   wire wr_irq_mask = WR_EN_IN && ADDR_IN == gmx_pkg::ADDR_IRQ_MASK;
   wire rd_irq_stat = RD_EN_IN && ADDR_IN == gmx_pkg::ADDR_IRQ_STAT;

   assign alm.clr = wr_clr ? WR_DATA_IN[gmx_pkg::NALM-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < gmx_pkg::NPIN; g++) begin : g_pin
         localparam logic [gmx_pkg::AW-1:0] CFG_ADDR =
            gmx_pkg::ADDR_CFG_BASE + gmx_pkg::AW'(g * gmx_pkg::CFG_STRIDE);
         logic alarm_raw;

         assign cfg_hit[g] = ADDR_IN == CFG_ADDR;
         assign cfg_rdv[g] = cfg_hit[g] ? cfg_r[g] : '0;
         assign mode_w[g]  = gmx_pkg::gmx_mode_e'(cfg_r[g][gmx_pkg::MODE_LSB +: gmx_pkg::MODE_W]);
         assign inv_w[g]   = cfg_r[g][gmx_pkg::INV_BIT];
         assign od_w[g]    = cfg_r[g][gmx_pkg::OD_BIT];
         assign src_w[g]   = cfg_r[g][gmx_pkg::SRC_LSB +: gmx_pkg::SRC_W];

         always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
            if (!rst_n) begin
               cfg_r[g] <= gmx_pkg::CFG_RST;
            end else if (WR_EN_IN && cfg_hit[g]) begin
               cfg_r[g] <= WR_DATA_IN[gmx_pkg::CFG_W-1:0];
            end
         end

         // same configuration gives same value on every pin
         always_comb begin
            case (mode_w[g])
               gmx_pkg::MODE_SIGMISS:     alarm_raw = SIGNAL_MISSING_ALARM_IN[src_w[g]];
               gmx_pkg::MODE_LOCK_LIVE:   alarm_raw = lock_loss_w[src_w[g]];
               gmx_pkg::MODE_LOCK_STICKY: alarm_raw = alm.sticky[gmx_pkg::LOCK_BASE + int'(src_w[g])];
               gmx_pkg::MODE_HOLD_LIVE:   alarm_raw = DIGITAL_LOCK_LOOP_HOLDOVER_IN[src_w[g]];
               gmx_pkg::MODE_HOLD_STICKY: alarm_raw = alm.sticky[gmx_pkg::HOLD_BASE + int'(src_w[g])];
               gmx_pkg::MODE_ALERT:       alarm_raw = alert_w;
               default:                   alarm_raw = 1'b0;
            endcase
         end

         always_comb begin
            case (mode_w[g])
               gmx_pkg::MODE_INPUT:  pin_nxt[g] = 1'b0;
               gmx_pkg::MODE_OUTPUT: pin_nxt[g] = out_val_r[g];
               default:              pin_nxt[g] = alarm_raw ^ inv_w[g];
            endcase
         end

         // open drain only enables the driver for a low level
         assign oe_nxt[g] = RESET_DONE_IN && mode_w[g] != gmx_pkg::MODE_INPUT
                            && (!od_w[g] || !pin_nxt[g]);
      end
   endgenerate

   always_comb begin
      cfg_rd = '0;
      for (int i = 0; i < gmx_pkg::NPIN; i++) begin
         cfg_rd = cfg_rd | cfg_rdv[i];
      end
   end

   assign rd_mux =
      (ADDR_IN == gmx_pkg::ADDR_IN_VAL)   ? gmx_pkg::DW'(in_val) :
      (ADDR_IN == gmx_pkg::ADDR_OUT_VAL)  ? gmx_pkg::DW'(out_val_r) :
      (ADDR_IN == gmx_pkg::ADDR_LIVE)     ? gmx_pkg::DW'(live_rd) :
      (ADDR_IN == gmx_pkg::ADDR_STICKY)   ? gmx_pkg::DW'(alm.sticky) :
      (ADDR_IN == gmx_pkg::ADDR_ALERT_EN) ? gmx_pkg::DW'(alert_en_r) :
      (ADDR_IN == gmx_pkg::ADDR_IRQ_STAT) ? gmx_pkg::DW'(irq_stat_r) :
      (ADDR_IN == gmx_pkg::ADDR_IRQ_MASK) ? gmx_pkg::DW'(irq_mask_r) :
      (|cfg_hit)                          ? gmx_pkg::DW'(cfg_rd) : '0;

   // software registers
   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         out_val_r  <= gmx_pkg::OUT_VAL_RST;
         alert_en_r <= gmx_pkg::ALERT_EN_RST;
         irq_mask_r <= gmx_pkg::IRQ_MASK_RST;
      end else begin
         if (wr_out_val) out_val_r <= WR_DATA_IN[gmx_pkg::NPIN-1:0];
         if (wr_alert_en) alert_en_r <= WR_DATA_IN[gmx_pkg::NALM-1:0];
         if (wr_irq_mask) irq_mask_r <= WR_DATA_IN[gmx_pkg::NALM-1:0];
      end
   end

   // interrupt status: set by alarm change, cleared by read, set wins
   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= '0;
         irq_r      <= 1'b0;
      end else begin
         irq_stat_r <= alm.evt | (rd_irq_stat ? '0 : irq_stat_r);
         irq_r      <= |(irq_stat_r & irq_mask_r);
      end
   end

   // pins and read data
   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         gpio_out_r <= '0;
         gpio_oe_r  <= '0;
         rd_data_r  <= '0;
      end else begin
         gpio_out_r <= RESET_DONE_IN ? pin_nxt : '0;
         gpio_oe_r  <= oe_nxt;
         rd_data_r  <= RD_EN_IN ? rd_mux : '0;
      end
   end

   assign GPIO_OUT    = gpio_out_r;
   assign GPIO_OE_OUT = gpio_oe_r;
   assign IRQ_OUT     = irq_r;
   assign RD_DATA_OUT = rd_data_r;

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!rst_n);

   a_pins_idle_reset: assert property (!RESET_DONE_IN |=> GPIO_OE_OUT == '0 && GPIO_OUT == '0)
      else $error("pin driven before reset sequence done");
   a_input_tracks_pin: assert property ($stable(GPIO_IN) [*6] |-> in_val == GPIO_IN)
      else $error("input register does not follow a steady pin");
   a_input_undriven: assert property (mode_w[0] == gmx_pkg::MODE_INPUT |=> !GPIO_OE_OUT[0])
      else $error("input mode pin is driven");
   a_output_level: assert property (RESET_DONE_IN && mode_w[0] == gmx_pkg::MODE_OUTPUT
      |=> GPIO_OUT[0] == $past(out_val_r[0]))
      else $error("output mode pin level wrong");
   a_sigmiss_follow: assert property (RESET_DONE_IN && mode_w[4] == gmx_pkg::MODE_SIGMISS && src_w[4] == 2'h1
      |=> GPIO_OUT[4] == ($past(SIGNAL_MISSING_ALARM_IN[1]) ^ $past(inv_w[4])))
      else $error("signal missing pin not following its monitor");
   a_lock_live: assert property (RESET_DONE_IN && mode_w[5] == gmx_pkg::MODE_LOCK_LIVE && src_w[5] == 2'h1 && !inv_w[5]
      |=> GPIO_OUT[5] == !($past(DIGITAL_LOCK_LOOP_LOCKED_IN[1]) && $past(ANALOG_LOCK_LOOP_LOCKED_IN)))
      else $error("live lock pin wrong");
   a_hold_live: assert property (RESET_DONE_IN && mode_w[6] == gmx_pkg::MODE_HOLD_LIVE && src_w[6] == 2'h3 && !inv_w[6]
      |=> GPIO_OUT[6] == $past(DIGITAL_LOCK_LOOP_HOLDOVER_IN[3]))
      else $error("live holdover pin wrong");
   a_sticky_lock_pin: assert property (RESET_DONE_IN && mode_w[7] == gmx_pkg::MODE_LOCK_STICKY && src_w[7] == 2'h0
      ##1 RESET_DONE_IN && $stable(cfg_r[7]) |=> GPIO_OUT[7] == ($past(alm.sticky[0]) ^ $past(inv_w[7])))
      else $error("sticky lock pin wrong");
   a_alert_or: assert property (RESET_DONE_IN && mode_w[0] == gmx_pkg::MODE_ALERT && !inv_w[0]
      |=> GPIO_OUT[0] == |($past(alm.sticky) & $past(alert_en_r)))
      else $error("alert pin is not the OR of enabled sticky flags");
   a_same_config: assert property (RESET_DONE_IN && cfg_r[1] == cfg_r[2] && mode_w[1] != gmx_pkg::MODE_OUTPUT
      |=> GPIO_OUT[1] == GPIO_OUT[2])
      else $error("identically configured pins differ");
   a_irq_level: assert property (irq_stat_r == '0 ##1 irq_stat_r == '0 |-> !IRQ_OUT)
      else $error("interrupt high with empty status");

   c_alert_raised: cover property (mode_w[0] == gmx_pkg::MODE_ALERT && !GPIO_OUT[0] ##1 GPIO_OUT[0]);
   c_sticky_cleared: cover property (alm.sticky[0] ##1 wr_clr ##1 !alm.sticky[0]);
   c_irq_read_clear: cover property (IRQ_OUT && rd_irq_stat ##2 !IRQ_OUT);
   c_output_toggle: cover property (mode_w[1] == gmx_pkg::MODE_OUTPUT && GPIO_OE_OUT[1] && $rose(GPIO_OUT[1]));
endmodule
`default_nettype wire

// *** verif/gmx_board_model.sv ***
// board side of the gpio pins: external drivers and pull-up resolution
`timescale 1ns/1ps
`default_nettype none
module gmx_board_model (
   input  wire logic [gmx_pkg::NPIN-1:0] pin_out_in,
   input  wire logic [gmx_pkg::NPIN-1:0] pin_oe_in,
   input  wire logic [gmx_pkg::NPIN-1:0] drv_val_in,
   input  wire logic [gmx_pkg::NPIN-1:0] drv_en_in,
   output logic      [gmx_pkg::NPIN-1:0] pin_level_out
);
   // device wins while enabled, then board driver, else pull-up
   assign pin_level_out = (pin_oe_in & pin_out_in)
                        | (~pin_oe_in & drv_en_in & drv_val_in)
                        | (~pin_oe_in & ~drv_en_in);
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the multi-mode gpio block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                          clk = 1'b0;
   logic                          rst_b = 1'b0;
   logic                          done = 1'b0;
   logic [gmx_pkg::NCH-1:0]       smiss = '0;
   logic [gmx_pkg::NCH-1:0]       dlock = 4'hF;
   logic [gmx_pkg::NCH-1:0]       dhold = '0;
   logic                          alock = 1'b1;
   logic [gmx_pkg::AW-1:0]        addr = '0;
   logic [gmx_pkg::DW-1:0]        wd = '0;
   logic                          we = 1'b0;
   logic                          re = 1'b0;
   logic [gmx_pkg::NPIN-1:0]      brd_val = '0;
   logic [gmx_pkg::NPIN-1:0]      brd_en = '0;
   logic [gmx_pkg::NPIN-1:0]      pin_lvl;
   logic [gmx_pkg::DW-1:0]        rdata;
   logic [gmx_pkg::NPIN-1:0]      gout;
   logic [gmx_pkg::NPIN-1:0]      goe;
   logic                          irq;
   int                            fail_count = 0;
   int                            n_checks = 0;

   always #2.5 clk = ~clk;

   gmx_gpio_top i_gmx_gpio_top (
      .REF_CLK_IN(clk), .RST_B_IN(rst_b), .RESET_DONE_IN(done), .GPIO_IN(pin_lvl),
      .SIGNAL_MISSING_ALARM_IN(smiss), .DIGITAL_LOCK_LOOP_LOCKED_IN(dlock),
      .DIGITAL_LOCK_LOOP_HOLDOVER_IN(dhold), .ANALOG_LOCK_LOOP_LOCKED_IN(alock),
      .ADDR_IN(addr), .WR_DATA_IN(wd), .WR_EN_IN(we), .RD_EN_IN(re),
      .RD_DATA_OUT(rdata), .GPIO_OUT(gout), .GPIO_OE_OUT(goe), .IRQ_OUT(irq));

   gmx_board_model i_gmx_board_model (
      .pin_out_in(gout), .pin_oe_in(goe), .drv_val_in(brd_val), .drv_en_in(brd_en),
      .pin_level_out(pin_lvl));

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd   <= d;
      we   <= 1'b1;
      @(posedge clk);
      we   <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      re   <= 1'b1;
      @(posedge clk);
      re   <= 1'b0;
      #1;
      chk(nm, rdata, exp);
   endtask

   function automatic logic [7:0] cfga(input int i);
      return gmx_pkg::ADDR_CFG_BASE + 8'(gmx_pkg::CFG_STRIDE * i);
   endfunction

   function automatic logic [31:0] cfgw(input logic [2:0] m, input logic inv, input logic [1:0] src);
      return 32'({src, inv, m});
   endfunction

   // drop all sticky flags and pending irq status
   task automatic clr_all();
      wr(gmx_pkg::ADDR_STICKY_CLR, 32'h0000_00FF);
      @(posedge clk);
      addr <= gmx_pkg::ADDR_IRQ_STAT;
      re   <= 1'b1;
      @(posedge clk);
      re   <= 1'b0;
      waitc(2);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("alert_en_rst", gmx_pkg::ADDR_ALERT_EN, 32'h0000_0000);
      rdc("irq_mask_rst", gmx_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      rdc("cfg1_rst", cfga(1), 32'h0000_0000);
      rdc("unmapped_rd", 8'h40, 32'h0000_0000);
      wr(cfga(0), cfgw(gmx_pkg::MODE_OUTPUT, 1'b0, 2'h0));
      wr(gmx_pkg::ADDR_OUT_VAL, 32'h0000_0001);
      waitc(3);
      chk("oe_in_reset", 32'(goe), 32'h0000_0000);
      chk("out_in_reset", 32'(gout), 32'h0000_0000);
      @(posedge clk) done <= 1'b1;
      waitc(3);
      chk("oe_after_done", 32'(goe), 32'h0000_0001);
      chk("out_after_done", 32'(gout), 32'h0000_0001);
      // pins 1..7 default to input mode
      @(posedge clk) brd_en <= 8'hFE;
      brd_val <= 8'hA4;
      waitc(8);
      rdc("in_val", gmx_pkg::ADDR_IN_VAL, 32'h0000_00A5);
      for (int i = 1; i < gmx_pkg::NPIN; i++) wr(cfga(i), cfgw(gmx_pkg::MODE_OUTPUT, 1'b0, 2'h0));
      @(posedge clk) brd_en <= 8'h00;
      wr(gmx_pkg::ADDR_OUT_VAL, 32'h0000_003C);
      waitc(3);
      chk("out_val_pins", 32'(gout), 32'h0000_003C);
      chk("out_oe", 32'(goe), 32'h0000_00FF);
      rdc("out_val_rd", gmx_pkg::ADDR_OUT_VAL, 32'h0000_003C);
      // open drain releases a high level
      wr(cfga(2), 32'h0000_0041);
      waitc(3);
      chk("od_oe", 32'(goe), 32'h0000_00FB);
      wr(cfga(1), cfgw(gmx_pkg::MODE_SIGMISS, 1'b0, 2'h2));
      wr(cfga(2), cfgw(gmx_pkg::MODE_SIGMISS, 1'b0, 2'h2));
      wr(cfga(3), cfgw(gmx_pkg::MODE_SIGMISS, 1'b1, 2'h2));
      wr(cfga(4), cfgw(gmx_pkg::MODE_SIGMISS, 1'b0, 2'h1));
      @(posedge clk) smiss <= 4'h4;
      waitc(3);
      chk("sigmiss_on", 32'(gout[4:1]), 32'h0000_0003);
      @(posedge clk) smiss <= 4'h0;
      waitc(3);
      chk("sigmiss_off", 32'(gout[4:1]), 32'h0000_0004);
      wr(cfga(5), cfgw(gmx_pkg::MODE_LOCK_LIVE, 1'b0, 2'h1));
      @(posedge clk) alock <= 1'b0;
      waitc(3);
      chk("lock_live_analog", 32'(gout[5]), 32'h0000_0001);
      @(posedge clk) alock <= 1'b1;
      waitc(3);
      chk("lock_live_ok", 32'(gout[5]), 32'h0000_0000);
      @(posedge clk) dlock[1] <= 1'b0;
      waitc(3);
      chk("lock_live_digital", 32'(gout[5]), 32'h0000_0001);
      @(posedge clk) dlock[1] <= 1'b1;
      wr(cfga(6), cfgw(gmx_pkg::MODE_LOCK_STICKY, 1'b0, 2'h0));
      wr(cfga(7), cfgw(gmx_pkg::MODE_LOCK_STICKY, 1'b1, 2'h0));
      clr_all();
      chk("lock_sticky_idle", 32'(gout[7:6]), 32'h0000_0002);
      @(posedge clk) dlock[0] <= 1'b0;
      waitc(3);
      chk("lock_sticky_exit", 32'(gout[7:6]), 32'h0000_0001);
      rdc("sticky_exit", gmx_pkg::ADDR_STICKY, 32'h0000_0001);
      waitc(4);
      chk("lock_sticky_hold", 32'(gout[7:6]), 32'h0000_0001);
      wr(gmx_pkg::ADDR_STICKY_CLR, 32'h0000_0001);
      waitc(3);
      chk("lock_sticky_clr", 32'(gout[7:6]), 32'h0000_0002);
      @(posedge clk) dlock[0] <= 1'b1;
      waitc(3);
      chk("lock_sticky_entry", 32'(gout[7:6]), 32'h0000_0001);
      wr(cfga(6), cfgw(gmx_pkg::MODE_HOLD_LIVE, 1'b0, 2'h3));
      wr(cfga(7), cfgw(gmx_pkg::MODE_HOLD_STICKY, 1'b0, 2'h3));
      clr_all();
      @(posedge clk) dhold[3] <= 1'b1;
      waitc(3);
      chk("hold_enter", 32'(gout[7:6]), 32'h0000_0003);
      @(posedge clk) dhold[3] <= 1'b0;
      waitc(3);
      chk("hold_leave", 32'(gout[7:6]), 32'h0000_0002);
      rdc("sticky_hold", gmx_pkg::ADDR_STICKY, 32'h0000_0080);
      wr(gmx_pkg::ADDR_STICKY_CLR, 32'h0000_0080);
      waitc(3);
      chk("hold_clr", 32'(gout[7:6]), 32'h0000_0000);
      wr(cfga(0), cfgw(gmx_pkg::MODE_ALERT, 1'b0, 2'h0));
      wr(cfga(1), cfgw(gmx_pkg::MODE_ALERT, 1'b1, 2'h0));
      wr(gmx_pkg::ADDR_ALERT_EN, 32'h0000_0011);
      rdc("alert_en_rd", gmx_pkg::ADDR_ALERT_EN, 32'h0000_0011);
      clr_all();
      @(posedge clk) dhold[1] <= 1'b1;
      waitc(3);
      chk("alert_not_enabled", 32'(gout[1:0]), 32'h0000_0002);
      @(posedge clk) dlock[0] <= 1'b0;
      dhold[0] <= 1'b1;
      waitc(3);
      chk("alert_set", 32'(gout[1:0]), 32'h0000_0001);
      rdc("live_rd", gmx_pkg::ADDR_LIVE, 32'h0000_0310);
      wr(gmx_pkg::ADDR_STICKY_CLR, 32'h0000_0001);
      waitc(3);
      chk("alert_partial_clr", 32'(gout[1:0]), 32'h0000_0001);
      wr(gmx_pkg::ADDR_STICKY_CLR, 32'h0000_0010);
      waitc(3);
      chk("alert_full_clr", 32'(gout[1:0]), 32'h0000_0002);
      clr_all();
      wr(gmx_pkg::ADDR_IRQ_MASK, 32'h0000_0010);
      @(posedge clk) dlock[0] <= 1'b1;
      waitc(3);
      chk("irq_masked", 32'(irq), 32'h0000_0000);
      wr(gmx_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      waitc(3);
      chk("irq_unmasked", 32'(irq), 32'h0000_0001);
      rdc("irq_stat", gmx_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
      waitc(3);
      chk("irq_cleared", 32'(irq), 32'h0000_0000);
      rdc("irq_stat_again", gmx_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      rdc("sticky_final", gmx_pkg::ADDR_STICKY, 32'h0000_0001);
      waitc(1);
      chk("rd_idle", rdata, 32'h0000_0000);
      summarize();
   end
endmodule
`default_nettype wire
